/* File: core/ewp_config.sv */
// Two-wire slave with protection/address configuration byte and write gating
module ewp_config #(
  parameter int WR_CYCLES = ewp_pkg::WR_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic memWrEn,
  output ewp_pkg::ewp_arr_wr_t memWr,
  output logic [ewp_pkg::ADDR_W-1:0] memRdAddr,
  input wire logic [7:0] memRdData,
  output logic busy
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic blockHit(input logic [7:0] cfg, input logic [ewp_pkg::ADDR_W-1:0] a);
    logic [1:0] q;
    q = a[ewp_pkg::ADDR_W-1 -: 2];
    blockHit = 1'b0;
    if (cfg[ewp_pkg::CFG_BLK_EN]) begin
      unique case (cfg[ewp_pkg::CFG_SIZE_HI:ewp_pkg::CFG_SIZE_LO])
        2'b00: blockHit = (q == 2'b11);
        2'b01: blockHit = q[1];
        2'b10: blockHit = (q != 2'b00);
        2'b11: blockHit = 1'b1;
      endcase
    end
  endfunction : blockHit

  // ----------------------------------------------------------------
  // Pin synchronisers and condition detect
  // ----------------------------------------------------------------
  logic [1:0] sclS_r;
  logic [1:0] sdaS_r;
  logic sclD_r;
  logic sdaD_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      sclS_r <= 2'b11;
      sdaS_r <= 2'b11;
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
    end else begin
      sclS_r <= {sclS_r[0], sclIn};
      sdaS_r <= {sdaS_r[0], sdaIn};
      sclD_r <= sclS_r[1];
      sdaD_r <= sdaS_r[1];
    end
  end

  logic scl;
  logic sda;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  assign scl = sclS_r[1];
  assign sda = sdaS_r[1];
  assign sclRise = scl & ~sclD_r;
  assign sclFall = ~scl & sclD_r;
  assign startCond = scl & sclD_r & sdaD_r & ~sda;
  assign stopCond = scl & sclD_r & ~sdaD_r & sda;

  // ----------------------------------------------------------------
  // Protocol engine and configuration state
  // ----------------------------------------------------------------
  ewp_pkg::ewp_state_t state_r;
  logic [3:0] bitCnt_r;
  logic [7:0] shift_r;
  logic [1:0] byteIdx_r;
  logic readMode_r;
  logic cfgSel_r;
  logic [ewp_pkg::ADDR_W-1:0] ptr_r;
  logic [7:0] cfg_r;
  logic swLock_r;
  logic wrPending_r;
  logic masterAck_r;
  logic busy_r;
  logic [ewp_pkg::BUSY_W-1:0] busyCnt_r;

  logic [7:0] rxByte;
  logic swBlocked;
  logic addrMatch;
  assign rxByte = shift_r;
  // Software lock only counts while its enable bit is set
  assign swBlocked = cfg_r[ewp_pkg::CFG_SW_EN] & swLock_r;
  assign addrMatch = (rxByte[7:4] == ewp_pkg::DEV_PREFIX)
                   && (rxByte[3:1] == cfg_r[ewp_pkg::CFG_DEV_HI:ewp_pkg::CFG_DEV_LO]);

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= ewp_pkg::ST_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      byteIdx_r <= 2'h0;
      readMode_r <= 1'b0;
      cfgSel_r <= 1'b0;
      ptr_r <= '0;
      cfg_r <= ewp_pkg::CFG_RESET;
      swLock_r <= ewp_pkg::SW_LOCK_RESET;
      wrPending_r <= 1'b0;
      masterAck_r <= 1'b0;
      sdaOe <= 1'b0;
      memWrEn <= 1'b0;
      memWr <= '0;
    end else begin
      memWrEn <= 1'b0;
      if (busy_r) begin
        state_r <= ewp_pkg::ST_IDLE;
        sdaOe <= 1'b0;
        wrPending_r <= 1'b0;
      end else if (startCond) begin
        state_r <= ewp_pkg::ST_RECV;
        bitCnt_r <= 4'h0;
        byteIdx_r <= 2'h0;
        sdaOe <= 1'b0;
      end else if (stopCond) begin
        state_r <= ewp_pkg::ST_IDLE;
        sdaOe <= 1'b0;
      end else begin
        unique case (state_r)
          ewp_pkg::ST_IDLE, ewp_pkg::ST_WAIT: begin
            sdaOe <= 1'b0;
          end
          ewp_pkg::ST_RECV: begin
            if (sclRise && bitCnt_r < 4'd8) begin
              shift_r <= {shift_r[6:0], sda};
              bitCnt_r <= bitCnt_r + 4'd1;
            end else if (sclFall && bitCnt_r == 4'd8) begin
              state_r <= ewp_pkg::ST_ACK;
              sdaOe <= 1'b1;
              if (byteIdx_r != 2'd3) begin
                byteIdx_r <= byteIdx_r + 2'd1;
              end
              unique case (byteIdx_r)
                2'd0: begin
                  if (rxByte == ewp_pkg::CMD_UNLOCK) begin
                    swLock_r <= 1'b0;
                    byteIdx_r <= 2'd3;
                    readMode_r <= 1'b0;
                  end else if (rxByte == ewp_pkg::CMD_LOCK) begin
                    swLock_r <= 1'b1;
                    byteIdx_r <= 2'd3;
                    readMode_r <= 1'b0;
                  end else if (addrMatch) begin
                    readMode_r <= rxByte[0];
                  end else begin
                    state_r <= ewp_pkg::ST_WAIT;
                    sdaOe <= 1'b0;
                  end
                end
                2'd1: begin
                  cfgSel_r <= rxByte[ewp_pkg::CFG_SEL_BIT];
                  ptr_r <= {rxByte[ewp_pkg::ADDR_W-9:0], ptr_r[7:0]};
                end
                2'd2: begin
                  ptr_r <= {ptr_r[ewp_pkg::ADDR_W-1:8], rxByte};
                end
                2'd3: begin
                  if (cfgSel_r) begin
                    cfg_r <= {1'b0, rxByte[6:0]};
                    wrPending_r <= 1'b1;
                  end else if (!swBlocked && !blockHit(cfg_r, ptr_r)) begin
                    memWrEn <= 1'b1;
                    memWr <= '{addr: ptr_r, data: rxByte};
                    wrPending_r <= 1'b1;
                  end
                  // Write pointer wraps within its page
                  ptr_r <= {ptr_r[ewp_pkg::ADDR_W-1:ewp_pkg::PAGE_BITS],
                            ptr_r[ewp_pkg::PAGE_BITS-1:0] + 5'd1};
                end
              endcase
            end
          end
          ewp_pkg::ST_ACK: begin
            if (sclFall) begin
              bitCnt_r <= 4'h0;
              if (readMode_r) begin
                state_r <= ewp_pkg::ST_SEND;
                shift_r <= cfgSel_r ? cfg_r : memRdData;
                sdaOe <= cfgSel_r ? ~cfg_r[7] : ~memRdData[7];
              end else begin
                state_r <= ewp_pkg::ST_RECV;
                sdaOe <= 1'b0;
              end
            end
          end
          ewp_pkg::ST_SEND: begin
            if (sclFall) begin
              if (bitCnt_r == 4'd7) begin
                state_r <= ewp_pkg::ST_MACK;
                sdaOe <= 1'b0;
                if (!cfgSel_r) begin
                  ptr_r <= ptr_r + 13'd1;
                end
              end else begin
                shift_r <= {shift_r[6:0], 1'b0};
                sdaOe <= ~shift_r[6];
                bitCnt_r <= bitCnt_r + 4'd1;
              end
            end
          end
          ewp_pkg::ST_MACK: begin
            if (sclRise) begin
              masterAck_r <= ~sda;
            end else if (sclFall) begin
              if (masterAck_r) begin
                state_r <= ewp_pkg::ST_SEND;
                bitCnt_r <= 4'h0;
                shift_r <= cfgSel_r ? cfg_r : memRdData;
                sdaOe <= cfgSel_r ? ~cfg_r[7] : ~memRdData[7];
              end else begin
                state_r <= ewp_pkg::ST_WAIT;
              end
            end
          end
          default: begin
            state_r <= ewp_pkg::ST_IDLE;
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Internal write cycle timer
  // ----------------------------------------------------------------
  // Worst-case figure is used so the array always has its full time
  always_ff @(posedge clock) begin
    if (rst) begin
      busy_r <= 1'b0;
      busyCnt_r <= '0;
    end else if (busy_r) begin
      busyCnt_r <= busyCnt_r - 1'b1;
      if (busyCnt_r == 1) begin
        busy_r <= 1'b0;
      end
    end else if (stopCond && wrPending_r) begin
      busy_r <= 1'b1;
      busyCnt_r <= ewp_pkg::BUSY_W'(WR_CYCLES);
    end
  end

  assign sdaOut = 1'b0;
  assign busy = busy_r;
  assign memRdAddr = ptr_r;
endmodule : ewp_config

/* File: core/ewp_pkg.sv */
// Package: constants, states and carriers of the write-protect configuration block
package ewp_pkg;
  // ----------------------------------------------------------------
  // Bus addressing
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_PREFIX = 4'hA;
  localparam logic [7:0] CMD_UNLOCK = 8'h80;
  localparam logic [7:0] CMD_LOCK = 8'hF0;
  localparam int CFG_SEL_BIT = 7;
  localparam int ADDR_W = 13;
  localparam int PAGE_BITS = 5;

  // ----------------------------------------------------------------
  // Configuration byte layout and reset values
  // ----------------------------------------------------------------
  localparam int CFG_DEV_HI = 6;
  localparam int CFG_DEV_LO = 4;
  localparam int CFG_BLK_EN = 3;
  localparam int CFG_SIZE_HI = 2;
  localparam int CFG_SIZE_LO = 1;
  localparam int CFG_SW_EN = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic SW_LOCK_RESET = 1'b1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 40000000;
  localparam longint WR_TIME_MS = 3;
  localparam int WR_CYCLES = int'((WR_TIME_MS * CLK_HZ) / 1000);
  localparam int BUSY_W = 17;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_ACK = 3'b010,
    ST_SEND = 3'b011,
    ST_MACK = 3'b100,
    ST_WAIT = 3'b101
  } ewp_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } ewp_arr_wr_t;
endpackage : ewp_pkg

/* File: dv/ewp_monitor.sv */
// Port checker for bus answer, array write pulse and busy span
module ewp_monitor #(
  parameter int WR_CYCLES = 50
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic memWrEn,
  input wire ewp_pkg::ewp_arr_wr_t memWr,
  input wire logic [ewp_pkg::ADDR_W-1:0] memRdAddr,
  input wire logic [7:0] memRdData,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 100ps;
  int busyCnt_r;
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  // ------------
  // Busy span
  // ------------
  always_ff @(posedge clock) begin
    if (rst) begin
      busyCnt_r <= 0;
    end else begin
      busyCnt_r <= busy ? busyCnt_r + 1 : 0;
    end
  end
  busy_span_a: assert property ($fell(busy) |-> busyCnt_r inside {[WR_CYCLES-2:WR_CYCLES]})
    else $error("busy span wrong");
  busy_quiet_a: assert property (busy |-> !sdaOe) else $error("answer while busy");
  write_idle_a: assert property (memWrEn |-> !busy) else $error("array write while busy");
  write_pulse_a: assert property (memWrEn |=> !memWrEn) else $error("write pulse too long");
  write_cycle_a: assert property (memWrEn |-> ##[1:600] busy) else $error("no write cycle");
  reset_idle_a: assert property ($fell(rst) |-> !busy && !sdaOe) else $error("not idle after reset");
  ack_low_a: assert property ($rose(sdaOe) |-> !sclIn) else $error("answer starts with clock high");
  ack_hold_a: assert property ($rose(sdaOe) |=> sdaOe [*8]) else $error("answer too short");
  cover property (memWrEn);
  cover property ($fell(busy));
  cover property ($rose(sdaOe));
endmodule : ewp_monitor
bind ewp_config ewp_monitor #(.WR_CYCLES(WR_CYCLES)) ewp_monitor_i (.clock(clock), .rst(rst), .sclIn(sclIn),
  .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .memWrEn(memWrEn), .memWr(memWr), .memRdAddr(memRdAddr),
  .memRdData(memRdData), .busy(busy));

/* File: dv/ewp_master.sv */
// Two-wire bus controller model: start, stop and byte transfers
module ewp_master (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sdaM
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sdaM = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic start();
    sdaM = 1'b1;
    tick(8);
    scl = 1'b1;
    tick(8);
    sdaM = 1'b0;
    tick(8);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    sdaM = 1'b0;
    tick(8);
    scl = 1'b1;
    tick(8);
    sdaM = 1'b1;
    tick(8);
  endtask : stop
  // Eight bits then the answer bit; a released line reads high
  task automatic xfer(input logic [7:0] d, input logic nack, output logic [7:0] q, output logic ack);
    logic [8:0] v;
    v = {d, nack};
    for (int i = 8; i >= 0; i--) begin
      sdaM = v[i];
      tick(8);
      scl = 1'b1;
      tick(4);
      v[i] = sda;
      tick(4);
      scl = 1'b0;
    end
    q = v[8:1];
    ack = ~v[0];
  endtask : xfer
endmodule : ewp_master

/* File: dv/tb_top.sv */
// Bench: frames through the controller model, write notes queue and scoreboard
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WR = 400;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic scl, sdaM, sdaOut, sdaOe, memWrEn, busy;
  // Open-drain line: the driven level only counts while the enable is up
  wire sda = sdaM & (sdaOe ? sdaOut : 1'b1);
  ewp_pkg::ewp_arr_wr_t memWr;
  ewp_pkg::ewp_arr_wr_t expQ[$];
  logic [ewp_pkg::ADDR_W-1:0] memRdAddr;
  logic [7:0] memRdData;
  logic [31:0] seed = 32'h0F5B735E;
  int n_mismatch = 0;
  int check_count = 0;
  int lo;
  always #12.5 clock = ~clock;
  assign memRdData = memRdAddr[7:0] ^ 8'h5A;
  ewp_config #(.WR_CYCLES(WR)) ewp_config_i (.clock(clock), .rst(rst), .sclIn(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .memWrEn(memWrEn), .memWr(memWr), .memRdAddr(memRdAddr),
    .memRdData(memRdData), .busy(busy));
  ewp_master ewp_master_i (.clock(clock), .sda(sda), .scl(scl), .sdaM(sdaM));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic check(input string what, input logic [20:0] exp, input logic [20:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  always @(posedge clock) begin
    if (memWrEn === 1'b1) begin
      check("wrExpected", 21'h1, 21'(expQ.size() > 0));
      if (expQ.size() > 0) check("memWr", expQ.pop_front(), memWr);
    end
  end
  task automatic frame(input logic [7:0] dev, input logic [15:0] a, input logic [7:0] d, input logic ack,
    input logic wr);
    logic [7:0] q;
    logic got;
    if (wr) expQ.push_back({a[12:0], d});
    ewp_master_i.start();
    ewp_master_i.xfer(dev, 1'b1, q, got);
    check("devAck", ack, got);
    if (got) begin
      ewp_master_i.xfer(a[15:8], 1'b1, q, got);
      ewp_master_i.xfer(a[7:0], 1'b1, q, got);
      ewp_master_i.xfer(d, 1'b1, q, got);
      check("dataAck", 1'b1, got);
    end
    ewp_master_i.stop();
    // Probe right after the stop: an answer means no write cycle was started
    if (ack) begin
      ewp_master_i.start();
      ewp_master_i.xfer(dev, 1'b1, q, got);
      check("busyAck", !(wr || a[15]), got);
      ewp_master_i.stop();
    end
    ewp_master_i.tick(20);
    for (int i = 0; i < WR + 20 && busy !== 1'b0; i++) ewp_master_i.tick(1);
    check("idle", 1'b0, busy);
  endtask : frame
  task automatic cmd(input logic [7:0] b);
    logic [7:0] q;
    logic got;
    ewp_master_i.start();
    ewp_master_i.xfer(b, 1'b1, q, got);
    check("cmdAck", 1'b1, got);
    ewp_master_i.stop();
  endtask : cmd
  task automatic read_cfg(input logic [7:0] dev, input logic [15:0] a, input logic [7:0] exp0,
    input logic [7:0] exp1);
    logic [7:0] q;
    logic got;
    ewp_master_i.start();
    ewp_master_i.xfer(dev, 1'b1, q, got);
    ewp_master_i.xfer(a[15:8], 1'b1, q, got);
    ewp_master_i.xfer(a[7:0], 1'b1, q, got);
    ewp_master_i.start();
    ewp_master_i.xfer(dev | 8'h01, 1'b1, q, got);
    ewp_master_i.xfer(8'hFF, 1'b0, q, got);
    check("cfgRead", exp0, q);
    ewp_master_i.xfer(8'hFF, 1'b1, q, got);
    check("nextRead", exp1, q);
    ewp_master_i.stop();
  endtask : read_cfg
  task automatic final_report();
    check("queueEmpty", 21'h0, 21'(expQ.size()));
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  initial begin
    #(25 * 60000);
    n_mismatch++;
    final_report();
  end
  initial begin
    ewp_master_i.tick(20);
    rst = 1'b0;
    ewp_master_i.tick(4);
    frame(8'hA0, 16'h6010, rnd(), 1'b1, 1'b1);
    $display("test plain write done");
    frame(8'hA0, 16'h8000, 8'h91, 1'b1, 1'b0);
    frame(8'hA0, 16'h0011, rnd(), 1'b0, 1'b0);
    read_cfg(8'hA2, 16'h8000, 8'h11, 8'h11);
    $display("test config done");
    frame(8'hA2, 16'h0020, rnd(), 1'b1, 1'b0);
    cmd(ewp_pkg::CMD_UNLOCK);
    frame(8'hA2, 16'h0021, rnd(), 1'b1, 1'b1);
    cmd(ewp_pkg::CMD_LOCK);
    frame(8'hA2, 16'h0022, rnd(), 1'b1, 1'b0);
    $display("test software lock done");
    read_cfg(8'hA2, 16'h0021, 8'h21 ^ 8'h5A, 8'h22 ^ 8'h5A);
    $display("test array read done");
    // Bit 0 clear here, so the armed lock must not matter
    for (int s = 0; s < 4; s++) begin
      frame(8'hA2, 16'h8000, {4'h1, 1'b1, 2'(s), 1'b0}, 1'b1, 1'b0);
      lo = 8192 - (s + 1) * 2048;
      frame(8'hA2, 16'(lo), rnd(), 1'b1, 1'b0);
      if (lo > 0) frame(8'hA2, 16'(lo - 1), rnd(), 1'b1, 1'b1);
    end
    $display("test block sizes done");
    // Unlock, then power up again: the lock must be armed afresh
    cmd(ewp_pkg::CMD_UNLOCK);
    rst = 1'b1;
    ewp_master_i.tick(20);
    rst = 1'b0;
    ewp_master_i.tick(4);
    frame(8'hA0, 16'h8000, 8'h01, 1'b1, 1'b0);
    frame(8'hA0, 16'h0030, rnd(), 1'b1, 1'b0);
    $display("test power-up relock done");
    final_report();
  end
endmodule : tb_top
